// file: include/erm_pkg.sv
// Package for the E1 receive monitor channel: register map, fields, timing counts.
// Assumes a 200 MHz system clock and a one-cycle recovered-bit strobe.
package erm_pkg;

  // Register offsets (byte-wide registers on the plain port)
  localparam logic [7:0] OFF_SOFT_RESET     = 8'h00;
  localparam logic [7:0] OFF_GLOBAL_CONTROL = 8'h0f;
  localparam logic [7:0] OFF_ALARM_STATUS   = 8'h13;
  localparam logic [7:0] OFF_ALARM_IE       = 8'h14;
  localparam logic [7:0] OFF_MODE_CTRL      = 8'h20;
  localparam logic [7:0] OFF_LINE_STATUS    = 8'h21;

  // Global control fields
  localparam int GC_AMI_BIT       = 4;
  localparam int GC_ALARM_INS_BIT = 6;
  // Mode control fields
  localparam int MC_ETSI_BIT      = 0;
  localparam int MC_DATAREC_BIT   = 1;
  localparam int MC_HOSTMODE_BIT  = 2;
  localparam int MC_NONMUX_BIT    = 3;

  // Reset values
  localparam logic [7:0] GLOBAL_CONTROL_RST = 8'h00;
  localparam logic [7:0] ALARM_IE_RST       = 8'h00;
  localparam logic [7:0] MODE_CTRL_RST      = 8'h04;

  // Timing
  localparam int CLK_MHZ           = 200;
  localparam int SOFT_RST_LONG_NS  = 2000;
  localparam int SOFT_RST_SHORT_NS = 1000;
  localparam int SOFT_RST_LONG_CYC  = SOFT_RST_LONG_NS * CLK_MHZ / 1000;
  localparam int SOFT_RST_SHORT_CYC = SOFT_RST_SHORT_NS * CLK_MHZ / 1000;
  localparam int AMP_LOSS_US       = 30;
  localparam int AMP_LOSS_CYC      = AMP_LOSS_US * CLK_MHZ;

  // Detection counts
  localparam int G775_LOSS_ZEROS   = 32;
  localparam int G775_WINDOW       = 32;
  localparam int G775_MIN_MARKS    = 4;
  localparam int G775_MAX_RUN      = 15;
  localparam int ETSI_LOSS_ZEROS   = 2048;
  localparam int ETSI_CLEAR_MARKS  = 32;
  localparam int AIS_WINDOW        = 512;
  localparam int AIS_MIN_ZEROS     = 3;
  localparam int UNIPOLAR_QUAL     = 16;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } erm_bus_t;

  // One received bit from the slicer
  typedef struct packed {
    logic valid;
    logic pos;
    logic neg;
  } erm_bit_t;

endpackage : erm_pkg

// file: src/erm_loss_detect.sv
// Zero-count loss-of-signal detector for one receive channel.
// Assumes bitIn.valid pulses once per recovered bit period.
`timescale 1ns/10ps
`default_nettype none
module erm_loss_detect
  #(parameter int ETSI_ZEROS = erm_pkg::ETSI_LOSS_ZEROS)
  (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic              clear,
  input  wire logic              etsiMode,
  input  wire erm_pkg::erm_bit_t bitIn,
  output logic                   lossFlag
  );
  import erm_pkg::*;

  logic [11:0] zeroCnt_r;
  logic [5:0]  runCnt_r;
  logic [G775_WINDOW-1:0] window_r;
  logic [5:0]  markRun_r;
  logic        mark;
  logic [5:0]  marksInWin;

  assign mark = bitIn.pos | bitIn.neg;
  assign marksInWin = 6'($countones(window_r));

  // Zero counter: count zeros, reset on mark, saturate at terminal count
  always_ff @(posedge clk)
  begin
    if (!rst_b || clear)
      zeroCnt_r <= 12'h000;
    else if (bitIn.valid)
    begin
      if (mark)
        zeroCnt_r <= 12'h000;
      else if (zeroCnt_r != 12'(ETSI_ZEROS))
        zeroCnt_r <= zeroCnt_r + 12'h001;
    end
  end

  // Sliding mark window and current zero run, for the G.775 clear test
  always_ff @(posedge clk)
  begin
    if (!rst_b || clear)
    begin
      window_r  <= '0;
      runCnt_r  <= 6'h00;
      markRun_r <= 6'h00;
    end
    else if (bitIn.valid)
    begin
      window_r  <= {window_r[G775_WINDOW-2:0], mark};
      runCnt_r  <= mark ? 6'h00 : (runCnt_r == 6'h3f ? runCnt_r : runCnt_r + 6'h01);
      markRun_r <= mark ? (markRun_r == 6'h3f ? markRun_r : markRun_r + 6'h01) : 6'h00;
    end
  end

  // Flag set and clear; set wins, since a clear needs recent marks anyway
  always_ff @(posedge clk)
  begin
    if (!rst_b || clear)
      lossFlag <= 1'b0;
    else if (!etsiMode && zeroCnt_r >= 12'(G775_LOSS_ZEROS))
      lossFlag <= 1'b1;
    else if (etsiMode && zeroCnt_r >= 12'(ETSI_ZEROS))
      lossFlag <= 1'b1;
    else if (!etsiMode && marksInWin >= 6'(G775_MIN_MARKS)
             && runCnt_r <= 6'(G775_MAX_RUN))
      lossFlag <= 1'b0;
    else if (etsiMode && markRun_r > 6'(ETSI_CLEAR_MARKS))
      lossFlag <= 1'b0;
  end

endmodule : erm_loss_detect
`default_nettype wire

// file: src/erm_rx_monitor.sv
// One E1 receive channel's digital monitor: reset, clock select, loss, alarm, violations.
// Assumes recovered bits and master-clock level arrive synchronous to clk.
// Functional notes
// - Reset register write starts timed reset cycle
// - Power-up reset loads defaults, clears loss
// - Clock recovery: output recovered clock
// - Data recovery: tristate or XOR per master
// - Zero counter increments, mark clears it
// - Loss swaps to master clock and back
// - Data outputs follow input during loss
// - G.775: loss after 32 zeros
// - G.775 clear: 4 marks, run under 16
// - ETSI: loss after 2048 zeros
// - ETSI clear: over 32 marked intervals
// - Select bit one chooses ETSI mode
// - Data recovery: amplitude loss after 30us
// - Alarm detect only host, clock recovery, master
// - Fewer than 3 zeros in 512 declares
// - Three or more zeros in 512 clears
// - Insert disabled: no insertion, status untouched
// - Insert enabled: all ones, status tracks input
// - Violations only after unipolar qualified 16 cycles
// - AMI: report every bipolar violation
// - HDB3: pulse non-substitution violations only
//
// The address-and-strobe port was decided locally.
`timescale 1ns/10ps
`default_nettype none
module erm_rx_monitor
  #(parameter int ETSI_ZEROS  = erm_pkg::ETSI_LOSS_ZEROS,
    parameter int AMP_CYC     = erm_pkg::AMP_LOSS_CYC,
    parameter int AIS_WIN     = erm_pkg::AIS_WINDOW)
  (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire erm_pkg::erm_bus_t bus,
  output logic [7:0]             rdata,
  input  wire erm_pkg::erm_bit_t bitIn,
  input  wire logic              recClk,
  input  wire logic              masterClk,
  input  wire logic              lowAmplitude,
  input  wire logic              unipolar_select_in,
  output logic                   rx_positive_data,
  output logic                   rx_negative_data,
  output logic                   rxDataValid,
  output logic                   rxClkOut,
  output logic                   rxClkOutEn,
  output logic                   signal_loss_flag,
  output logic                   code_violation_out,
  output logic                   inResetCycle
  );
  import erm_pkg::*;

  logic [7:0]  globalControl_r;
  logic [7:0]  alarmIe_r;
  logic [7:0]  modeCtrl_r;
  logic        alarmStatus_r;
  logic [11:0] rstCnt_r;
  logic        softRst;
  logic        blockClr;
  logic        zeroLoss;
  logic        ampLoss_r;
  logic [15:0] ampCnt_r;
  logic        lossNow;
  logic        useMaster_r;
  logic        mPrev_r;
  logic [4:0]  ubsCnt_r;
  logic        unipolar_r;
  logic [9:0]  aisBits_r;
  logic [1:0]  aisZeros_r;
  logic        aisDetect_r;
  logic        lastPol_r;
  logic        havePulse_r;
  logic [1:0]  zerosSince_r;
  logic [7:0]  mIdle_r;
  logic        masterActive;
  logic        etsi;
  logic        dataRec;
  logic        ampLossUsed;

  // Mode decode and status taps
  assign etsi     = modeCtrl_r[MC_ETSI_BIT];
  assign dataRec  = modeCtrl_r[MC_DATAREC_BIT];
  assign softRst  = rstCnt_r != 12'h000;
  assign blockClr = softRst;
  assign inResetCycle = softRst;
  assign ampLossUsed  = dataRec & ampLoss_r;
  assign lossNow  = dataRec ? ampLoss_r : zeroLoss;
  assign signal_loss_flag = lossNow;
  assign masterActive = ~&mIdle_r; // Saturated idle count means a stalled master

  // Reset cycle length depends on processor bus mode
  function automatic logic [11:0] rstLen(input logic nonMux);
    rstLen = nonMux ? 12'(SOFT_RST_LONG_CYC) : 12'(SOFT_RST_SHORT_CYC);
  endfunction : rstLen

  // Reset cycle timer; registers held at defaults while it runs
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rstCnt_r <= 12'h000;
    else if (bus.wr && bus.addr == OFF_SOFT_RESET)
      rstCnt_r <= rstLen(modeCtrl_r[MC_NONMUX_BIT]);
    else if (softRst)
      rstCnt_r <= rstCnt_r - 12'h001;
  end

  // Writable registers; writes during a reset cycle are dropped
  always_ff @(posedge clk)
  begin
    if (!rst_b || softRst)
    begin
      globalControl_r <= GLOBAL_CONTROL_RST;
      alarmIe_r       <= ALARM_IE_RST;
      modeCtrl_r      <= MODE_CTRL_RST;
    end
    else if (bus.wr)
    begin
      if (bus.addr == OFF_GLOBAL_CONTROL)
        globalControl_r <= bus.wdata;
      else if (bus.addr == OFF_ALARM_IE)
        alarmIe_r <= bus.wdata;
      else if (bus.addr == OFF_MODE_CTRL)
        modeCtrl_r <= bus.wdata;
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rdata <= 8'h00;
    else if (bus.rd)
    begin
      if (bus.addr == OFF_GLOBAL_CONTROL)
        rdata <= globalControl_r;
      else if (bus.addr == OFF_ALARM_STATUS)
        rdata <= {7'h00, alarmStatus_r};
      else if (bus.addr == OFF_ALARM_IE)
        rdata <= alarmIe_r;
      else if (bus.addr == OFF_MODE_CTRL)
        rdata <= modeCtrl_r;
      else if (bus.addr == OFF_LINE_STATUS)
        rdata <= {4'h0, unipolar_r, aisDetect_r, ampLossUsed, lossNow};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // Zero-count detector, cleared by either reset
  erm_loss_detect #(.ETSI_ZEROS(ETSI_ZEROS)) uLoss
  (
    .clk      (clk),
    .rst_b    (rst_b),
    .clear    (blockClr),
    .etsiMode (etsi),
    .bitIn    (bitIn),
    .lossFlag (zeroLoss)
  );

  // Self-timed amplitude qualification used in data-recovery mode
  always_ff @(posedge clk)
  begin
    if (!rst_b || blockClr || !lowAmplitude)
    begin
      ampCnt_r  <= 16'h0000;
      ampLoss_r <= 1'b0;
    end
    else if (ampCnt_r >= 16'(AMP_CYC))
      ampLoss_r <= 1'b1;
    else
      ampCnt_r <= ampCnt_r + 16'h0001;
  end

  // Clock source flag; return to recovered clock waits for a master edge
  // so the switch lands cleanly rather than mid-phase
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      useMaster_r <= 1'b0;
      mPrev_r     <= 1'b0;
    end
    else
    begin
      mPrev_r <= masterClk;
      if (zeroLoss)
        useMaster_r <= 1'b1;
      else if (masterClk != mPrev_r)
        useMaster_r <= 1'b0;
    end
  end

  // Master clock activity: alarm windows count only while the master runs,
  // since a stalled master leaves them no time base; the saturating count
  // puts the stall limit near 1.3 us, above any master half period
  always_ff @(posedge clk)
  begin
    if (!rst_b || masterClk != mPrev_r)
      mIdle_r <= 8'h00;
    else if (masterActive)
      mIdle_r <= mIdle_r + 8'h01;
  end

  // Receive clock output mux
  always_comb
  begin
    if (dataRec)
    begin
      rxClkOutEn = masterClk;
      rxClkOut   = masterClk & (rx_positive_data ^ rx_negative_data);
    end
    else
    begin
      rxClkOutEn = 1'b1;
      rxClkOut   = useMaster_r ? masterClk : recClk;
    end
  end

  // Unipolar qualification: select must stay high over 16 master cycles
  always_ff @(posedge clk)
  begin
    if (!rst_b || !unipolar_select_in)
    begin
      ubsCnt_r   <= 5'h00;
      unipolar_r <= 1'b0;
    end
    else if (masterClk && !mPrev_r)
    begin
      if (ubsCnt_r >= 5'(UNIPOLAR_QUAL))
        unipolar_r <= 1'b1;
      else
        ubsCnt_r <= ubsCnt_r + 5'h01;
    end
  end

  // Alarm detection: count zeros over fixed windows of recovered bits
  always_ff @(posedge clk)
  begin
    if (!rst_b || blockClr)
    begin
      aisBits_r   <= 10'h000;
      aisZeros_r  <= 2'h0;
      aisDetect_r <= 1'b0;
    end
    else if (bitIn.valid && modeCtrl_r[MC_HOSTMODE_BIT] && !dataRec && masterActive)
    begin
      if (aisBits_r == 10'(AIS_WIN - 1))
      begin
        aisBits_r   <= 10'h000;
        aisZeros_r  <= 2'h0;
        aisDetect_r <= (aisZeros_r + 2'(!(bitIn.pos | bitIn.neg))) < 2'(AIS_MIN_ZEROS)
                       && aisZeros_r != 2'h3;
      end
      else
      begin
        aisBits_r <= aisBits_r + 10'h001;
        if (!(bitIn.pos | bitIn.neg) && aisZeros_r != 2'h3)
          aisZeros_r <= aisZeros_r + 2'h1;
      end
    end
  end

  // Alarm status: with insertion enabled during loss it tracks the input content
  always_ff @(posedge clk)
  begin
    if (!rst_b || blockClr)
      alarmStatus_r <= 1'b0;
    else if (lossNow && globalControl_r[GC_ALARM_INS_BIT])
    begin
      if (bitIn.valid)
        alarmStatus_r <= !(bitIn.pos | bitIn.neg);
    end
    else if (!lossNow)
      alarmStatus_r <= aisDetect_r;
    else
      alarmStatus_r <= alarmStatus_r;
  end

  // Data outputs follow the line; all ones only when inserting
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      rx_positive_data <= 1'b0;
      rx_negative_data <= 1'b0;
      rxDataValid      <= 1'b0;
    end
    else
    begin
      rxDataValid <= bitIn.valid;
      if (bitIn.valid)
      begin
        if (lossNow && globalControl_r[GC_ALARM_INS_BIT])
        begin
          rx_positive_data <= 1'b1;
          rx_negative_data <= 1'b1;
        end
        else
        begin
          rx_positive_data <= bitIn.pos;
          rx_negative_data <= bitIn.neg;
        end
      end
    end
  end

  // Violation check; in HDB3 a violation after fewer than 3 zeros is a substitution
  always_ff @(posedge clk)
  begin
    if (!rst_b || blockClr)
    begin
      lastPol_r          <= 1'b0;
      havePulse_r        <= 1'b0;
      zerosSince_r       <= 2'h0;
      code_violation_out <= 1'b0;
    end
    else if (bitIn.valid)
    begin
      code_violation_out <= 1'b0;
      if (bitIn.pos ^ bitIn.neg)
      begin
        if (unipolar_r && havePulse_r && lastPol_r == bitIn.pos)
        begin
          if (globalControl_r[GC_AMI_BIT])
            code_violation_out <= 1'b1;
          else if (zerosSince_r == 2'h3)
            code_violation_out <= 1'b1;
        end
        lastPol_r    <= bitIn.pos;
        havePulse_r  <= 1'b1;
        zerosSince_r <= 2'h0;
      end
      else if (zerosSince_r != 2'h3)
        zerosSince_r <= zerosSince_r + 2'h1;
    end
  end

endmodule : erm_rx_monitor
`default_nettype wire

// file: bench/erm_rx_monitor_props.sv
// Port-level checks for one receive monitor channel.
// Assumes lowAmplitude stays low outside data recovery and mode writes come over bus.
`timescale 1ns/10ps
`default_nettype none
module erm_rx_monitor_props
  #(parameter int ETSI_ZEROS = erm_pkg::ETSI_LOSS_ZEROS)
  (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire erm_pkg::erm_bus_t bus,
  input  wire logic [7:0]        rdata,
  input  wire erm_pkg::erm_bit_t bitIn,
  input  wire logic              recClk,
  input  wire logic              masterClk,
  input  wire logic              unipolar_select_in,
  input  wire logic              rx_positive_data,
  input  wire logic              rx_negative_data,
  input  wire logic              rxDataValid,
  input  wire logic              rxClkOut,
  input  wire logic              rxClkOutEn,
  input  wire logic              signal_loss_flag,
  input  wire logic              inResetCycle
  );
  import erm_pkg::*;
  logic [7:0]  mode_r;
  logic        ins_r;
  logic [11:0] zc_r;
  logic [8:0]  rc_r;
  logic        dr;
  int          lim;
  assign dr  = mode_r[MC_DATAREC_BIT];
  assign lim = mode_r[MC_ETSI_BIT] ? ETSI_ZEROS : G775_LOSS_ZEROS;
  // Shadow of mode and insert bits; soft reset forces defaults like the real registers
  always_ff @(posedge clk)
    if (!rst_b || inResetCycle)
      mode_r <= MODE_CTRL_RST;
    else if (bus.wr && bus.addr == OFF_MODE_CTRL)
      mode_r <= bus.wdata;
  always_ff @(posedge clk)
    if (!rst_b || inResetCycle)
      ins_r <= 1'b0;
    else if (bus.wr && bus.addr == OFF_GLOBAL_CONTROL)
      ins_r <= bus.wdata[GC_ALARM_INS_BIT];
  // Zero run length; saturates so a long outage never looks short
  always_ff @(posedge clk)
    if (!rst_b || inResetCycle)
      zc_r <= 12'h000;
    else if (bitIn.valid)
      zc_r <= (bitIn.pos || bitIn.neg) ? 12'h000 : zc_r + {11'h000, zc_r != 12'hfff};
  // Length of the running soft reset cycle
  always_ff @(posedge clk)
    rc_r <= (rst_b && inResetCycle) ? rc_r + 9'h001 : 9'h000;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_quiet8;
    (!dr && !signal_loss_flag) [*8];
  endsequence
  sequence s_lost8;
    (!dr && signal_loss_flag) [*8];
  endsequence
  sequence s_bipolar;
    (!unipolar_select_in) [*8];
  endsequence
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 8'h00)
    else $error("read data outside read slot");
  a_clk_recover: assert property (s_quiet8 |-> rxClkOut == recClk && rxClkOutEn)
    else $error("receive clock not recovered clock");
  a_loss_master: assert property (s_lost8 |-> rxClkOut == masterClk)
    else $error("receive clock not master clock in loss");
  a_datarec_clk: assert property (dr |-> rxClkOutEn == masterClk &&
    (!masterClk || rxClkOut == (rx_positive_data ^ rx_negative_data)))
    else $error("data recovery clock output wrong");
  a_data_follow: assert property (s_bipolar ##0 bitIn.valid && !(ins_r && signal_loss_flag)
    |=> rx_positive_data == $past(bitIn.pos) && rx_negative_data == $past(bitIn.neg))
    else $error("data outputs not following line");
  a_insert_ones: assert property (bitIn.valid && ins_r && signal_loss_flag
    |=> rx_positive_data && rx_negative_data)
    else $error("alarm insertion not all ones");
  a_loss_early: assert property ($rose(signal_loss_flag) && !dr |-> zc_r >= lim)
    else $error("loss raised before zero count");
  a_loss_hold: assert property (!dr && !inResetCycle && zc_r > lim |-> signal_loss_flag)
    else $error("loss missing after zero run");
  a_reset_len: assert property ($fell(inResetCycle) |->
    rc_r == SOFT_RST_SHORT_CYC || rc_r == SOFT_RST_LONG_CYC)
    else $error("soft reset cycle length wrong");
  a_valid_follow: assert property (rxDataValid == $past(bitIn.valid))
    else $error("data valid not one cycle after bit strobe");
endmodule : erm_rx_monitor_props
bind erm_rx_monitor erm_rx_monitor_props #(.ETSI_ZEROS(ETSI_ZEROS)) u_props
  (.clk(clk), .rst_b(rst_b), .bus(bus), .rdata(rdata), .bitIn(bitIn), .recClk(recClk),
  .masterClk(masterClk), .unipolar_select_in(unipolar_select_in),
  .rx_positive_data(rx_positive_data), .rx_negative_data(rx_negative_data),
  .rxDataValid(rxDataValid),
  .rxClkOut(rxClkOut), .rxClkOutEn(rxClkOutEn), .signal_loss_flag(signal_loss_flag),
  .inResetCycle(inResetCycle));
`default_nettype wire

// file: bench/erm_line_model.sv
// Line-side model: a bit strobe every 4 clocks plus recovered and master clock levels.
// Assumes the bench changes the pattern select by non-blocking writes.
`timescale 1ns/10ps
`default_nettype none
module erm_line_model
  (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic [1:0]       pat,
  output var erm_pkg::erm_bit_t bitOut,
  output logic                  recClk,
  output logic                  masterClk
  );
  import erm_pkg::*;
  logic [2:0] ph_r;
  logic       pol_r;
  // Phase counter; master clock is a free slower reference
  always_ff @(posedge clk)
    ph_r <= rst_b ? ph_r + 3'h1 : 3'h0;
  // Mark polarity alternates per bit, as on a clean AMI line
  always_ff @(posedge clk)
    pol_r <= rst_b && (pol_r ^ bitOut.valid);
  assign recClk    = ph_r[1];
  assign masterClk = ph_r[2];
  // Pattern 0 zeros, 1 alternating marks, 2 positive marks only;
  // junk between strobes so nothing leans on stale levels
  always_comb
  begin
    bitOut.valid = rst_b && ph_r[1:0] == 2'h3;
    bitOut.pos   = bitOut.valid ? pat == 2'h2 || (pat == 2'h1 && pol_r) : ph_r[0];
    bitOut.neg   = bitOut.valid ? pat == 2'h1 && !pol_r : !ph_r[0];
  end
endmodule : erm_line_model
`default_nettype wire

// file: bench/tb.sv
// Self-checking bench for one receive monitor channel.
// Assumes the line model supplies bits and both clock levels.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, v) \
  begin checks_done++; if ((v) !== (e)) begin n_fail++; \
  $display("wrong value %s exp %0h got %0h", nm, e, v); end end
module tb;
  import erm_pkg::*;
  localparam int EZ = 64;
  logic       clk = 1'b0;
  logic       rst_b = 1'b0;
  erm_bus_t   bus = '0;
  logic [1:0] pat = 2'h1;
  logic       lowAmp = 1'b0;
  logic       uni = 1'b0;
  logic [7:0] rdata;
  erm_bit_t   bitIn;
  logic       recClk, masterClk, rxP, rxN, rxV, rxC, rxCE, loss, cv, inRst;
  int         n_fail = 0;
  int         checks_done = 0;
  int         n;
  erm_line_model line (.clk(clk), .rst_b(rst_b), .pat(pat), .bitOut(bitIn),
    .recClk(recClk), .masterClk(masterClk));
  erm_rx_monitor #(.ETSI_ZEROS(EZ), .AMP_CYC(20), .AIS_WIN(16)) uut (.clk(clk),
    .rst_b(rst_b), .bus(bus), .rdata(rdata), .bitIn(bitIn), .recClk(recClk),
    .masterClk(masterClk), .lowAmplitude(lowAmp), .unipolar_select_in(uni),
    .rx_positive_data(rxP), .rx_negative_data(rxN), .rxDataValid(rxV), .rxClkOut(rxC),
    .rxClkOutEn(rxCE), .signal_loss_flag(loss), .code_violation_out(cv),
    .inResetCycle(inRst));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus.wr <= 1'b1;
    bus.addr <= a;
    bus.wdata <= v;
    @(posedge clk);
    bus.wr <= 1'b0;
    @(posedge clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus.rd <= 1'b1;
    bus.addr <= a;
    @(posedge clk);
    bus.rd <= 1'b0;
    @(posedge clk);
    `CHK("rdata", e, rdata)
  endtask : rd
  // Counts bit strobes until the loss flag reaches v
  task automatic upto(input logic v);
    n = 0;
    for (int i = 0; i < 20000 && loss !== v; i++)
    begin
      @(posedge clk);
      n += int'(bitIn.valid === 1'b1);
    end
  endtask : upto
  task automatic cvs(input logic e);
    n = 0;
    repeat (200)
    begin
      @(posedge clk);
      n += int'(cv === 1'b1);
    end
    `CHK("violations", e, n > 0)
  endtask : cvs
  task automatic cyc(input int e);
    n = 0;
    while (inRst === 1'b1 && n < 1000)
    begin
      n++;
      @(posedge clk);
    end
    `CHK("reset cycles", e, n)
  endtask : cyc
  task automatic t_regs;
    rd(OFF_GLOBAL_CONTROL, GLOBAL_CONTROL_RST);
    rd(OFF_ALARM_IE, ALARM_IE_RST);
    rd(OFF_MODE_CTRL, MODE_CTRL_RST);
    rd(OFF_LINE_STATUS, 8'h00);
    rd(8'h55, 8'h00);
    wr(OFF_ALARM_IE, 8'ha5);
    rd(OFF_ALARM_IE, 8'ha5);
    wr(OFF_ALARM_STATUS, 8'hff);
    rd(OFF_ALARM_STATUS, 8'h00);
  endtask : t_regs
  task automatic t_g775;
    pat <= 2'h0;
    upto(1'b1);
    `CHK("zeros to loss", G775_LOSS_ZEROS, n)
    repeat (1200) @(posedge clk);
    `CHK("held loss", 1'b1, loss)
    pat <= 2'h1;
    upto(1'b0);
    `CHK("marks to clear", G775_MIN_MARKS, n)
  endtask : t_g775
  task automatic t_etsi;
    wr(OFF_MODE_CTRL, 8'h05);
    pat <= 2'h0;
    upto(1'b1);
    `CHK("etsi zeros", EZ, n)
    pat <= 2'h1;
    upto(1'b0);
    `CHK("etsi marks", ETSI_CLEAR_MARKS + 1, n)
    wr(OFF_MODE_CTRL, MODE_CTRL_RST);
  endtask : t_etsi
  // Alarm detect, then insertion off and on during a zero outage
  task automatic t_ais;
    repeat (200) @(posedge clk);
    rd(OFF_LINE_STATUS, 8'h04);
    pat <= 2'h0;
    repeat (200) @(posedge clk);
    rd(OFF_LINE_STATUS, 8'h01);
    rd(OFF_ALARM_STATUS, 8'h00);
    wr(OFF_ALARM_IE, 8'h00);
    wr(OFF_GLOBAL_CONTROL, 8'h40);
    repeat (100) @(posedge clk);
    rd(OFF_ALARM_STATUS, 8'h01);
    wr(OFF_GLOBAL_CONTROL, 8'h00);
    pat <= 2'h1;
    upto(1'b0);
    wr(OFF_MODE_CTRL, 8'h00);
    repeat (200) @(posedge clk);
    rd(OFF_LINE_STATUS, 8'h00);
    wr(OFF_MODE_CTRL, MODE_CTRL_RST);
  endtask : t_ais
  task automatic t_viol;
    wr(OFF_GLOBAL_CONTROL, 8'h10);
    pat <= 2'h2;
    cvs(1'b0);
    uni <= 1'b1;
    repeat (200) @(posedge clk);
    cvs(1'b1);
    wr(OFF_GLOBAL_CONTROL, 8'h00);
    repeat (20) @(posedge clk);
    cvs(1'b0);
    uni <= 1'b0;
    pat <= 2'h1;
    repeat (40) @(posedge clk);
  endtask : t_viol
  task automatic t_datarec;
    wr(OFF_MODE_CTRL, 8'h06);
    lowAmp <= 1'b1;
    repeat (15) @(posedge clk);
    `CHK("early loss", 1'b0, loss)
    repeat (10) @(posedge clk);
    `CHK("amplitude loss", 1'b1, loss)
    lowAmp <= 1'b0;
    repeat (5) @(posedge clk);
    `CHK("amplitude back", 1'b0, loss)
    wr(OFF_MODE_CTRL, MODE_CTRL_RST);
  endtask : t_datarec
  task automatic t_srst;
    wr(OFF_GLOBAL_CONTROL, 8'h50);
    wr(OFF_SOFT_RESET, 8'h00);
    cyc(SOFT_RST_SHORT_CYC);
    rd(OFF_GLOBAL_CONTROL, GLOBAL_CONTROL_RST);
    wr(OFF_MODE_CTRL, 8'h0c);
    wr(OFF_SOFT_RESET, 8'h00);
    cyc(SOFT_RST_LONG_CYC);
    rd(OFF_MODE_CTRL, MODE_CTRL_RST);
  endtask : t_srst
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_g775();
    t_etsi();
    t_ais();
    t_viol();
    t_datarec();
    t_srst();
    summarize();
  end
  // Watchdog, well beyond the expected run of some 4000 cycles
  initial
  begin
    #200000;
    n_fail++;
    summarize();
  end
endmodule : tb
`default_nettype wire
